//--- logic/scd_decoder.v
// servo command decoder: parses host commands and holds their results
//
// Contract
// R01 - position reset pulses encoder counter clear
// R02 - host avoids position reset during trapezoidal move
// R03 - address command sets node address, reset 0x00
// R04 - second byte sets group address, reset 0xFF
// R05 - bit7 clear means leader, stored bit7 high
// R06 - first address command drops chain enable low
// R07 - mask bits 0-4 select position through home
// R08 - mask bits 5-7 select id, error, points
// R09 - mask bits 8,9,12,13 select inputs, watchdog, motor
// R10 - host sends zero in reserved mask bits
// R11 - packet: status byte, items ascending, checksum
// R12 - define status stores mask, reply uses it
// R13 - persistent mask resets to zero
// R14 - read status mask applies once only
// R15 - trajectory fields in order, low byte first
// R16 - single drive byte clears upper byte
// R17 - control bits select servo, profile, direction
// R18 - bit7 applies now, else wait for start
// R19 - position, velocity, acceleration stored as goals
// R20 - drive reaches amplifier only with servo off
// R21 - status bit0 reports move done
// R22 - host starts trapezoid only at zero velocity
// R23 - command byte: count high nibble, code low
`timescale 1ns/100ps
`default_nettype none
`include "scd_regs.vh"

module scd_decoder #(
  // identification bytes: values are arbitrary
  parameter [7:0] DEVICE_ID  = 8'hA5,
  parameter [7:0] VERSION_ID = 8'h03
) (
  input  wire        clk,
  input  wire        reset,
  input  wire        rx_valid,
  input  wire        rx_first,
  input  wire [7:0]  rx_data,
  input  wire [7:0]  status_flags,
  input  wire        move_done,
  input  wire        servo_auto_off,
  input  wire [7:0]  item_data_ext,
  input  wire        tx_ready,
  output reg         pos_clear,
  output reg  [7:0]  node_addr,
  output reg  [7:0]  group_addr,
  output reg         group_leader,
  output reg         chain_out_n,
  output reg  [15:0] status_mask,
  output reg  [31:0] goal_pos,
  output reg  [31:0] goal_vel,
  output reg  [31:0] goal_acc,
  output reg  [15:0] drive_value,
  output reg  [15:0] amp_drive,
  output reg         servo_on,
  output reg         vel_mode,
  output reg         reverse,
  output reg         motion_go,
  output wire [3:0]  item_sel,
  output wire [2:0]  item_byte,
  output wire        tx_valid,
  output wire [7:0]  tx_data,
  output wire        tx_busy
);

  // --------------------------------------------------------------
  // parser state
  // --------------------------------------------------------------
  reg        in_cmd;
  reg        done;
  reg  [3:0] code;
  reg  [3:0] count;
  reg  [3:0] idx;
  reg  [7:0] data0;
  reg  [7:0] data1;
  reg  [7:0] ctrl;
  reg  [7:0] pend_ctrl;
  reg        pend_valid;
  reg  [31:0] stg_pos;
  reg  [31:0] stg_vel;
  reg  [31:0] stg_acc;
  reg  [15:0] stg_drive;

  wire [3:0]  off;
  wire [3:0]  pos_end;
  wire [3:0]  vel_end;
  wire [3:0]  acc_end;
  wire [15:0] given_mask;
  wire [15:0] reply_mask;
  wire [7:0]  status_byte;
  wire [7:0]  item_data;
  wire        traj_byte;
  wire        last_byte;

  // put one byte into a 32-bit word, little-endian position
  function [31:0] put_byte;
    input [31:0] word;
    input [1:0]  pos;
    input [7:0]  b;
    begin
      put_byte = word;
      case (pos)
        2'h0: put_byte[7:0]   = b;
        2'h1: put_byte[15:8]  = b;
        2'h2: put_byte[23:16] = b;
        default: put_byte[31:24] = b;
      endcase
    end
  endfunction

  // --------------------------------------------------------------
  // trajectory field boundaries, counted from the first value byte
  // --------------------------------------------------------------
  assign off       = idx - 4'h1;
  assign pos_end   = ctrl[`SCD_TC_POS] ? 4'h4 : 4'h0;                // R15
  assign vel_end   = pos_end + (ctrl[`SCD_TC_VEL] ? 4'h4 : 4'h0);
  assign acc_end   = vel_end + (ctrl[`SCD_TC_ACC] ? 4'h4 : 4'h0);
  assign traj_byte = rx_valid && !rx_first && in_cmd &&
                     (code == `SCD_CMD_LOAD_TRAJ) && (idx != 4'h0);
  assign last_byte = (idx == count - 4'h1);

  // --------------------------------------------------------------
  // byte intake
  // --------------------------------------------------------------
  // a fresh command byte always restarts parsing, so a lost tail
  // from the host cannot shift the next command's fields
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      in_cmd <= 1'b0;
      done   <= 1'b0;
      code   <= 4'h0;
      count  <= 4'h0;
      idx    <= 4'h0;
      data0  <= 8'h00;
      data1  <= 8'h00;
      ctrl   <= 8'h00;
    end else begin
      done <= 1'b0;
      if (rx_valid && rx_first) begin
        code   <= rx_data[`SCD_CMD_CODE];                            // R23
        count  <= rx_data[`SCD_CMD_COUNT];                           // R23
        idx    <= 4'h0;
        in_cmd <= (rx_data[`SCD_CMD_COUNT] != 4'h0);
        done   <= (rx_data[`SCD_CMD_COUNT] == 4'h0);
      end else if (rx_valid && in_cmd) begin
        if (idx == 4'h0) begin
          data0 <= rx_data;
          if (code == `SCD_CMD_LOAD_TRAJ) begin
            ctrl <= rx_data;
          end
        end
        if (idx == 4'h1) begin
          data1 <= rx_data;
        end
        idx <= idx + 4'h1;
        if (last_byte) begin
          in_cmd <= 1'b0;
          done   <= 1'b1;
        end
      end
    end
  end

  // --------------------------------------------------------------
  // trajectory staging
  // --------------------------------------------------------------
  // only fields named in the control byte are touched; others keep
  // whatever was staged before
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      stg_pos   <= 32'h00000000;
      stg_vel   <= 32'h00000000;
      stg_acc   <= 32'h00000000;
      stg_drive <= 16'h0000;
    end else if (traj_byte) begin
      if (off < pos_end) begin
        stg_pos <= put_byte(stg_pos, off[1:0], rx_data);             // R15
      end else if (off < vel_end) begin
        stg_vel <= put_byte(stg_vel, off[1:0], rx_data);             // R15
      end else if (off < acc_end) begin
        stg_acc <= put_byte(stg_acc, off[1:0], rx_data);             // R15
      end else if (ctrl[`SCD_TC_DRIVE] && off == acc_end) begin
        stg_drive <= {8'h00, rx_data};                               // R16
      end else if (ctrl[`SCD_TC_DRIVE] && off == acc_end + 4'h1) begin
        stg_drive[15:8] <= rx_data;
      end
    end
  end

  // --------------------------------------------------------------
  // command execution
  // --------------------------------------------------------------
  assign given_mask = (count == 4'h1) ? {8'h00, data0} : {data1, data0};
  // the answering packet of a status command already uses its mask
  assign reply_mask = (code == `SCD_CMD_DEF_STATUS ||
                       code == `SCD_CMD_READ_STATUS) ?
                      given_mask : status_mask;                      // R12 R14

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      pos_clear    <= 1'b0;
      node_addr    <= `SCD_NODE_RST;                                 // R03
      group_addr   <= `SCD_GROUP_RST;                                // R04
      group_leader <= 1'b0;
      chain_out_n  <= 1'b1;
      status_mask  <= `SCD_MASK_RST;                                 // R13
      pend_ctrl    <= 8'h00;
      pend_valid   <= 1'b0;
    end else begin
      pos_clear <= 1'b0;
      if (done) begin
        case (code)
          `SCD_CMD_RESET_POS: begin
            pos_clear <= 1'b1;                                       // R01
          end
          `SCD_CMD_SET_ADDR: begin
            if (count == `SCD_ADDR_COUNT) begin
              node_addr    <= data0;                                 // R03
              group_addr   <= {1'b1, data1[6:0]};                    // R04 R05
              group_leader <= ~data1[`SCD_GROUP_BIT];                // R05
              chain_out_n  <= 1'b0;                                  // R06
            end
          end
          `SCD_CMD_DEF_STATUS: begin
            status_mask <= given_mask;                               // R12
          end
          `SCD_CMD_LOAD_TRAJ: begin
            pend_ctrl  <= ctrl;
            pend_valid <= ~ctrl[`SCD_TC_NOW];                        // R18
          end
          `SCD_CMD_START: begin
            pend_valid <= 1'b0;
          end
          default: begin
            pend_valid <= pend_valid;
          end
        endcase
      end
    end
  end

  // --------------------------------------------------------------
  // active motion parameters
  // --------------------------------------------------------------
  // an automatic servo shutdown wins over a load in the same cycle for servo_on and drive_value
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      goal_pos    <= 32'h00000000;
      goal_vel    <= 32'h00000000;
      goal_acc    <= 32'h00000000;
      drive_value <= 16'h0000;
      servo_on    <= 1'b0;
      vel_mode    <= 1'b0;
      reverse     <= 1'b0;
      motion_go   <= 1'b0;
    end else begin
      motion_go <= 1'b0;
      if (done && ((code == `SCD_CMD_LOAD_TRAJ && ctrl[`SCD_TC_NOW]) ||
                   (code == `SCD_CMD_START && pend_valid))) begin   // R18
        goal_pos  <= stg_pos;                                        // R19
        goal_vel  <= stg_vel;                                        // R19
        goal_acc  <= stg_acc;                                        // R19
        servo_on  <= (code == `SCD_CMD_START) ? pend_ctrl[`SCD_TC_SERVO] :
                     ctrl[`SCD_TC_SERVO];                            // R17
        vel_mode  <= (code == `SCD_CMD_START) ? pend_ctrl[`SCD_TC_VELMODE] :
                     ctrl[`SCD_TC_VELMODE];                          // R17
        reverse   <= (code == `SCD_CMD_START) ? pend_ctrl[`SCD_TC_REV] :
                     ctrl[`SCD_TC_REV];                              // R17
        motion_go <= 1'b1;
        drive_value <= stg_drive;
      end
      if (servo_auto_off) begin
        servo_on    <= 1'b0;
        drive_value <= 16'h0000;                                     // R20
      end
    end
  end

  // raw drive reaches the amplifier only with the servo off
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      amp_drive <= 16'h0000;
    end else begin
      amp_drive <= servo_on ? 16'h0000 : drive_value;                // R20
    end
  end

  // --------------------------------------------------------------
  // status packet
  // --------------------------------------------------------------
  assign status_byte = {status_flags[7:1], move_done};               // R21
  // identification item is answered here; the rest come from outside
  assign item_data = (item_sel != `SCD_ITEM_ID) ? item_data_ext :
                     (item_byte == 3'h0) ? DEVICE_ID : VERSION_ID;   // R08

  scd_packet u_packet (
    .clk         (clk),
    .reset       (reset),
    .start       (done),
    .mask        (reply_mask),                                       // R07 R08 R09
    .status_byte (status_byte),
    .item_data   (item_data),
    .tx_ready    (tx_ready),
    .tx_valid    (tx_valid),
    .tx_data     (tx_data),
    .item_sel    (item_sel),
    .item_byte   (item_byte),
    .busy        (tx_busy)
  );

endmodule
`default_nettype wire

//--- logic/scd_packet.v
// status packet sequencer: status byte, selected items, checksum
`timescale 1ns/100ps
`default_nettype none
`include "scd_regs.vh"

module scd_packet (
  input  wire        clk,
  input  wire        reset,
  input  wire        start,
  input  wire [15:0] mask,
  input  wire [7:0]  status_byte,
  input  wire [7:0]  item_data,
  input  wire        tx_ready,
  output reg         tx_valid,
  output reg  [7:0]  tx_data,
  output reg  [3:0]  item_sel,
  output reg  [2:0]  item_byte,
  output wire        busy
);

  // --------------------------------------------------------------
  // states and lookups
  // --------------------------------------------------------------
  localparam [1:0] ST_IDLE  = 2'b00;
  localparam [1:0] ST_DATA  = 2'b01;
  localparam [1:0] ST_FETCH = 2'b10;
  localparam [1:0] ST_SUM   = 2'b11;

  reg  [1:0]  state;
  reg  [15:0] rem;
  reg  [7:0]  csum;
  wire [15:0] rem_after;
  wire        item_last;

  // byte count of each status item
  function [2:0] item_len;
    input [3:0] sel;
    begin
      case (sel)
        4'h0, 4'h4: item_len = 3'h4;
        4'h1, 4'h3, 4'h7: item_len = 3'h1;
        4'hD: item_len = 3'h6;
        default: item_len = 3'h2;
      endcase
    end
  endfunction

  // lowest selected item still to send
  function [3:0] lowest;
    input [15:0] m;
    integer i;
    begin
      lowest = 4'h0;
      for (i = 15; i >= 0; i = i - 1) begin
        if (m[i]) begin
          lowest = i[3:0];
        end
      end
    end
  endfunction

  assign busy      = (state != ST_IDLE);
  assign item_last = (item_byte == item_len(item_sel) - 3'h1);
  // status byte leaves rem untouched; a finished item drops its bit
  assign rem_after = (state == ST_DATA && rem[item_sel] && item_last) ?
                     (rem & ~(16'h0001 << item_sel)) : rem;

  // --------------------------------------------------------------
  // sequencer
  // --------------------------------------------------------------
  // fetch cycle lets the item source answer the new selector
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      state     <= ST_IDLE;
      rem       <= 16'h0000;
      csum      <= 8'h00;
      tx_valid  <= 1'b0;
      tx_data   <= 8'h00;
      item_sel  <= 4'h0;
      item_byte <= 3'h0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (start) begin
            rem      <= mask & `SCD_MASK_VALID;
            tx_data  <= status_byte;     // R11
            csum     <= status_byte;
            tx_valid <= 1'b1;
            item_sel <= 4'hF;            // no item while the status byte goes
            state    <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (tx_ready) begin
            tx_valid <= 1'b0;
            rem      <= rem_after;
            if (rem[item_sel] && !item_last) begin
              item_byte <= item_byte + 3'h1;
              state     <= ST_FETCH;
            end else if (rem_after != 16'h0000) begin
              item_sel  <= lowest(rem_after);  // R11
              item_byte <= 3'h0;
              state     <= ST_FETCH;
            end else begin
              tx_data  <= csum;          // R11
              tx_valid <= 1'b1;
              state    <= ST_SUM;
            end
          end
        end
        ST_FETCH: begin
          tx_data  <= item_data;
          csum     <= csum + item_data;
          tx_valid <= 1'b1;
          state    <= ST_DATA;
        end
        ST_SUM: begin
          if (tx_ready) begin
            tx_valid <= 1'b0;
            state    <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

endmodule
`default_nettype wire

//--- logic/scd_regs.vh
// constants shared by the servo command decoder files
`ifndef SCD_REGS_VH
`define SCD_REGS_VH

// command codes (low nibble of the command byte)
`define SCD_CMD_RESET_POS   4'h0
`define SCD_CMD_SET_ADDR    4'h1
`define SCD_CMD_DEF_STATUS  4'h2
`define SCD_CMD_READ_STATUS 4'h3
`define SCD_CMD_LOAD_TRAJ   4'h4
`define SCD_CMD_START       4'h5

// command byte layout
`define SCD_CMD_CODE        3:0
`define SCD_CMD_COUNT       7:4
`define SCD_ADDR_COUNT      4'h2

// reset values
`define SCD_NODE_RST        8'h00
`define SCD_GROUP_RST       8'hFF
`define SCD_MASK_RST        16'h0000
`define SCD_GROUP_BIT       7

// status mask: bits 10, 11, 14, 15 are reserved
`define SCD_MASK_VALID      16'h33FF
`define SCD_ITEM_ID         4'h5

// trajectory control byte fields
`define SCD_TC_POS          0
`define SCD_TC_VEL          1
`define SCD_TC_ACC          2
`define SCD_TC_DRIVE        3
`define SCD_TC_SERVO        4
`define SCD_TC_VELMODE      5
`define SCD_TC_REV          6
`define SCD_TC_NOW          7

// status byte: move done flag position
`define SCD_ST_DONE         0

`endif

//--- sim/scd_decoder_properties.sv
// concurrent checks on the servo command decoder ports
`timescale 1ns/100ps
`default_nettype none
module scd_decoder_props (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        rx_valid,
  input wire logic        rx_first,
  input wire logic [7:0]  rx_data,
  input wire logic [7:0]  status_flags,
  input wire logic        move_done,
  input wire logic        servo_auto_off,
  input wire logic        tx_ready,
  input wire logic        pos_clear,
  input wire logic [7:0]  node_addr,
  input wire logic [7:0]  group_addr,
  input wire logic        chain_out_n,
  input wire logic [15:0] status_mask,
  input wire logic [31:0] goal_pos,
  input wire logic [31:0] goal_vel,
  input wire logic [31:0] goal_acc,
  input wire logic [15:0] drive_value,
  input wire logic [15:0] amp_drive,
  input wire logic        servo_on,
  input wire logic        motion_go,
  input wire logic [3:0]  item_sel,
  input wire logic        tx_valid,
  input wire logic [7:0]  tx_data,
  input wire logic        tx_busy
);
  // -----------------------------------------
  // one clock domain, reset aborts every check
  // -----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  AST_POS_CLEAR: assert property (
    rx_valid && rx_first && rx_data == 8'h00 |-> ##[1:3] pos_clear)
    else $error("position clear pulse missing");
  AST_CHAIN_LOW: assert property (
    !chain_out_n |=> !chain_out_n)
    else $error("chain enable rose again");
  AST_GROUP_HIGH: assert property (
    group_addr[7])
    else $error("group address below 0x80");
  AST_AMP_DRIVE: assert property (
    1'b1 |=> amp_drive == ($past(servo_on) ? 16'h0000 : $past(drive_value)))
    else $error("amplifier drive wrong for servo state");
  AST_AUTO_OFF: assert property (
    servo_auto_off |=> drive_value == 16'h0000 && !servo_on)
    else $error("drive value kept after servo disable");
  AST_TX_HOLD: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("packet byte dropped while stalled");
  AST_STATUS_FIRST: assert property (
    $rose(tx_busy) |-> ##[0:3]
      (tx_valid && item_sel == 4'hF && tx_data == {status_flags[7:1], move_done}))
    else $error("packet does not open with status byte");
  AST_GOALS_APPLY: assert property (
    $changed(goal_pos) || $changed(goal_vel) || $changed(goal_acc)
      |-> motion_go || $past(motion_go))
    else $error("goal changed without apply pulse");
  AST_MASK_CMD: assert property (
    $changed(status_mask) |-> $past(rx_valid, 2) || $past(rx_valid, 3) || $past(rx_valid, 4))
    else $error("status mask changed without command");
endmodule

bind scd_decoder scd_decoder_props chk_u (
  .clk, .reset, .rx_valid, .rx_first, .rx_data, .status_flags, .move_done,
  .servo_auto_off, .tx_ready, .pos_clear, .node_addr, .group_addr, .chain_out_n,
  .status_mask, .goal_pos, .goal_vel, .goal_acc, .drive_value, .amp_drive,
  .servo_on, .motion_go, .item_sel, .tx_valid, .tx_data, .tx_busy
);
`default_nettype wire

//--- sim/scd_decoder_test.sv
// self-checking bench for the servo command decoder
`timescale 1ns/100ps
`default_nettype none
module scd_decoder_test;
  localparam logic [7:0] ID0 = 8'h5A; // arbitrary id value
  localparam logic [7:0] ID1 = 8'h17; // arbitrary version value
  logic        clk = 1'b0;
  logic        reset, slow, move_done, servo_auto_off;
  logic        rx_valid, rx_first, tx_ready, tx_valid, tx_busy;
  logic [7:0]  rx_data, status_flags, tx_data, node_addr, group_addr;
  logic        pos_clear, group_leader, chain_out_n, servo_on, vel_mode, reverse, motion_go;
  logic [15:0] status_mask, drive_value, amp_drive, m;
  logic [31:0] goal_pos, goal_vel, goal_acc;
  logic [3:0]  item_sel;
  logic [2:0]  item_byte;
  logic [7:0]  item_data_ext;
  logic [7:0]  exp_q[$];
  int          n_errors = 0;
  int          checks_done = 0;
  int          n_clr = 0;
  int          n_go = 0;

  // 200 MHz
  initial forever #2.5 clk = ~clk;
  // item bytes tagged with their item and index so order errors show
  assign item_data_ext = {item_sel, 1'b0, item_byte};
  always @(posedge clk) begin
    if (pos_clear === 1'b1) n_clr <= n_clr + 1;
    if (motion_go === 1'b1) n_go <= n_go + 1;
  end

  scd_decoder #(.DEVICE_ID(ID0), .VERSION_ID(ID1)) dut_u (
    .clk, .reset, .rx_valid, .rx_first, .rx_data, .status_flags, .move_done,
    .servo_auto_off, .item_data_ext, .tx_ready, .pos_clear, .node_addr, .group_addr,
    .group_leader, .chain_out_n, .status_mask, .goal_pos, .goal_vel, .goal_acc,
    .drive_value, .amp_drive, .servo_on, .vel_mode, .reverse, .motion_go,
    .item_sel, .item_byte, .tx_valid, .tx_data, .tx_busy
  );
  scd_host_model host_u (
    .clk, .slow, .tx_valid, .tx_data, .tx_ready, .rx_valid, .rx_first, .rx_data
  );

  // ---------------------------------
  // compare, expected packet, closing
  // ---------------------------------
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  function automatic void expect_pkt(input logic [15:0] mk);
    int len[16] = '{4, 1, 2, 1, 4, 2, 2, 1, 2, 2, 0, 0, 2, 6, 0, 0};
    logic [7:0] s;
    logic [7:0] b;
    exp_q = {};
    s = {status_flags[7:1], move_done};
    exp_q.push_back(s);
    for (int k = 0; k < 16; k++)
      for (int j = 0; j < len[k] && mk[k]; j++) begin
        b = (k == 5) ? ((j == 0) ? ID0 : ID1) : {k[3:0], 1'b0, j[2:0]};
        exp_q.push_back(b);
        s = s + b;
      end
    exp_q.push_back(s);
  endfunction

  // send one command, wait for its whole packet, compare byte by byte
  task automatic run(input logic [7:0] b[$], input logic [15:0] mk);
    expect_pkt(mk);
    host_u.got = {};
    host_u.send(b);
    for (int t = 0; t < 300 && host_u.got.size() < exp_q.size(); t++)
      @(posedge clk);
    repeat (3) @(posedge clk);
    #1;
    check("pkt_len", 32'(exp_q.size()), 32'(host_u.got.size()));
    foreach (exp_q[i])
      check("pkt_byte", exp_q[i], host_u.got[i]);
    @(posedge clk);
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    give_verdict;
  end

  // ------------
  // test sequence
  // ------------
  initial begin
    reset = 1'b1;
    slow = 1'b0;
    move_done = 1'b0;
    servo_auto_off = 1'b0;
    status_flags = 8'hA4;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1;
    check("node_addr", 8'h00, node_addr);
    check("group_addr", 8'hFF, group_addr);
    check("status_mask", 16'h0000, status_mask);
    check("chain_out_n", 1'b1, chain_out_n);
    @(posedge clk);
    // motor idle here, so a position reset is allowed
    run({8'h00}, 16'h0000);
    check("pos_clear_count", 32'h1, 32'(n_clr));
    run({8'h21, 8'h05, 8'h13}, 16'h0000);
    check("node_addr", 8'h05, node_addr);
    check("group_addr", 8'h93, group_addr);
    check("group_leader", 1'b1, group_leader);
    check("chain_out_n", 1'b0, chain_out_n);
    run({8'h21, 8'h07, 8'h85}, 16'h0000);
    check("group_addr", 8'h85, group_addr);
    check("group_leader", 1'b0, group_leader);
    move_done <= 1'b1;
    // let the new flag settle before the expected packet is built
    @(posedge clk);
    // reserved mask bits always sent as zero
    run({8'h22, 8'h21, 8'h30}, 16'h3021);
    check("status_mask", 16'h3021, status_mask);
    slow <= 1'b1;
    for (int k = 0; k < 14; k++)
      if (k != 10 && k != 11) begin
        m = 16'h0001 << k;
        run({8'h23, m[7:0], m[15:8]}, m);
      end
    run({8'h13, 8'h82}, 16'h0082);
    run({8'h0E}, 16'h3021);
    check("status_mask", 16'h3021, status_mask);
    slow <= 1'b0;
    run({8'hF4, 8'h9F, 8'h78, 8'h56, 8'h34, 8'h12, 8'h44, 8'h33, 8'h22, 8'h11,
         8'h0D, 8'h0C, 8'h0B, 8'h0A, 8'hEF, 8'hBE}, 16'h3021);
    check("goal_pos", 32'h12345678, goal_pos);
    check("goal_vel", 32'h11223344, goal_vel);
    check("goal_acc", 32'h0A0B0C0D, goal_acc);
    check("drive_value", 16'hBEEF, drive_value);
    check("servo_on", 1'b1, servo_on);
    check("amp_drive", 16'h0000, amp_drive);
    check("go_count", 32'h1, 32'(n_go));
    // deferred load; trapezoid restarted only with the motor at rest
    run({8'h94, 8'h15, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00},
        16'h3021);
    check("goal_pos", 32'h12345678, goal_pos);
    check("go_count", 32'h1, 32'(n_go));
    run({8'h05}, 16'h3021);
    check("goal_pos", 32'h00000100, goal_pos);
    check("goal_acc", 32'h00000200, goal_acc);
    check("goal_vel", 32'h11223344, goal_vel);
    run({8'h24, 8'hE8, 8'h7F}, 16'h3021);
    check("drive_value", 16'h007F, drive_value);
    check("vel_mode", 1'b1, vel_mode);
    check("reverse", 1'b1, reverse);
    check("servo_on", 1'b0, servo_on);
    check("amp_drive", 16'h007F, amp_drive);
    servo_auto_off <= 1'b1;
    @(posedge clk);
    servo_auto_off <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    check("drive_value", 16'h0000, drive_value);
    check("amp_drive", 16'h0000, amp_drive);
    @(posedge clk);
    // second reset: chain enable and addresses return to defaults
    reset <= 1'b1;
    // two edges in reset, so no history check spans the jump to defaults
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1;
    check("chain_out_n", 1'b1, chain_out_n);
    check("group_addr", 8'hFF, group_addr);
    @(posedge clk);
    run({8'h21, 8'h09, 8'hA0}, 16'h0000);
    check("chain_out_n", 1'b0, chain_out_n);
    check("node_addr", 8'h09, node_addr);
    give_verdict;
  end
endmodule
`default_nettype wire

//--- sim/scd_host_model.sv
// host side model: sends command bytes and sinks status packets
`timescale 1ns/100ps
`default_nettype none
module scd_host_model (
  input  wire logic       clk,
  input  wire logic       slow,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            tx_ready,
  output logic            rx_valid,
  output logic            rx_first,
  output logic [7:0]      rx_data
);
  logic [7:0] got[$];
  logic       tick = 1'b0;

  initial begin
    rx_valid = 1'b0;
    rx_first = 1'b0;
    rx_data  = 8'h00;
  end

  // slow host stalls every other cycle so held bytes get exercised
  assign tx_ready = !slow || tick;
  always @(posedge clk) begin
    tick <= ~tick;
    if (tx_valid && tx_ready)
      got.push_back(tx_data);
  end

  // count in high nibble, code low; bytes back to back, then line flips
  task automatic send(input logic [7:0] b[$]);
    foreach (b[i]) begin
      rx_valid <= 1'b1;
      rx_first <= (i == 0);
      rx_data  <= b[i];
      @(posedge clk);
    end
    rx_valid <= 1'b0;
    rx_first <= 1'b0;
    rx_data  <= ~b[b.size()-1];
  endtask
endmodule
`default_nettype wire
